// ---- design/dac_word_decoder.sv ----
// Serial control-word decoder for an eight-channel converter, with APB view.
// Assumes frame select, serial clock, data and strobe pin are asynchronous
// pins, sampled by sys_clk, which must run well above the serial clock.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
module dac_word_decoder
  import dac_word_decoder_pkg::*;
#(
  parameter int DATA_W = 12
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic syncN,
  input wire logic sclk,
  input wire logic din,
  input wire logic loadStrobeN,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output codeBank_t dacCode,
  output groupCfg_t groupCfg,
  output logic [`CHANNELS-1:0] powerDown,
  output logic rxPowered
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Only these code widths have a defined place in the word
  if (DATA_W != 8 && DATA_W != 10 && DATA_W != 12) begin : g_badWidth
    $error("DATA_W must be 8, 10 or 12");
  end

  state_t s_r;
  state_t s_nxt;

  // Word code, top DATA_W bits of the field, left-aligned into storage
  function automatic logic [`CODE_MAX_W-1:0] wordCode(input logic [`WORD_BITS-1:0] w);
    logic [`CODE_MAX_W-1:0] c;
    c = '0;
    c[`CODE_MAX_W-1 -: DATA_W] = w[`CODE_MAX_W-1 -: DATA_W];
    return c;
  endfunction : wordCode

  // Supply reference overrides drive and range
  function automatic groupCfg_t effCfg(input groupCfg_t c);
    groupCfg_t e;
    e = c;
    e.gain = c.gain & ~c.supplyRef;
    e.buffered = c.buffered & ~c.supplyRef;
    return e;
  endfunction : effCfg

  function automatic logic [31:0] cfgWord(input state_t st);
    return {16'h0000, st.powerDown, st.stbMode, st.cfgOut};
  endfunction : cfgWord

  logic sclkFall;
  logic syncLow;
  logic wordDone;
  logic [`WORD_BITS-1:0] word;
  logic strobe;
  logic apbAccess;
  logic apbSetup;
  logic codeSel;

  always_comb begin
    s_nxt = s_r;
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    s_nxt.syncN = {s_r.syncN[0], syncN};
    s_nxt.sclk = {s_r.sclk[0], sclk};
    s_nxt.din = {s_r.din[0], din};
    s_nxt.loadN = {s_r.loadN[0], loadStrobeN};
    s_nxt.sclkLast = s_r.sclk[1];
    s_nxt.loadLast = s_r.loadN[1];
    syncLow = ~s_r.syncN[1] & s_r.ctrlEn;
    sclkFall = s_r.sclkLast & ~s_r.sclk[1];
    wordDone = 1'b0;
    word = s_r.shift;

    // ************************************************************
    // Frame receiver
    // ************************************************************
    s_nxt.rxPowered = syncLow;
    unique case (s_r.rx)
      RX_IDLE: begin
        s_nxt.bitCnt = 5'h00;
        if (syncLow) begin
          s_nxt.rx = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (!syncLow) begin
          // Short frame: nothing committed
          s_nxt.rx = RX_IDLE;
          s_nxt.abortCnt = s_r.abortCnt + 8'h01;
        end else if (sclkFall) begin
          word = {s_r.shift[`WORD_BITS-2:0], s_r.din[1]};
          s_nxt.shift = word;
          s_nxt.bitCnt = s_r.bitCnt + 5'h01;
          if (s_r.bitCnt == 5'(`WORD_BITS - 1)) begin
            // Commit on the sixteenth edge itself
            wordDone = 1'b1;
            s_nxt.rx = RX_DONE;
          end
        end
      end
      RX_DONE: begin
        // Extra edges in the same frame are ignored
        if (!syncLow) begin
          s_nxt.rx = RX_IDLE;
        end
      end
      default: begin
        s_nxt.rx = RX_IDLE;
      end
    endcase

    // ************************************************************
    // Output-register transfer
    // ************************************************************
    strobe = (s_r.stbMode == `STB_TRACK) || !s_r.loadN[1] || s_r.singlePend;
    s_nxt.singlePend = 1'b0;
    if (strobe) begin
      for (int i = 0; i < `CHANNELS; i++) begin
        if (s_r.dirty[i]) begin
          s_nxt.dacCode[i] = s_r.inCode[i];
          s_nxt.dirty[i] = 1'b0;
        end
      end
      if (s_r.cfgDirty) begin
        s_nxt.cfgOut = s_r.cfgIn;
        s_nxt.cfgDirty = 1'b0;
      end
    end

    // ************************************************************
    // Word decode; a write in the strobe cycle keeps its dirty bit
    // ************************************************************
    if (wordDone) begin
      s_nxt.frameCnt = s_r.frameCnt + 8'h01;
      if (!word[`BIT_KIND]) begin
        s_nxt.inCode[word[`ADDR_HI:`ADDR_LO]] = wordCode(word);
        s_nxt.dirty[word[`ADDR_HI:`ADDR_LO]] = 1'b1;
      end else begin
        unique case (word[`BIT_CTL_HI:`BIT_CTL_LO])
          `CTL_CFG: begin
            s_nxt.cfgIn.gain = word[5:4];
            s_nxt.cfgIn.buffered = word[3:2];
            s_nxt.cfgIn.supplyRef = word[1:0];
            s_nxt.cfgDirty = 1'b1;
          end
          `CTL_STROBE: begin
            if (word[1:0] != `STB_RSVD) begin
              s_nxt.stbMode = word[1:0];
            end
            s_nxt.singlePend = (word[1:0] == `STB_SINGLE);
          end
          `CTL_PDOWN: begin
            s_nxt.powerDown = word[7:0];
          end
          `CTL_RESET: begin
            s_nxt.inCode = '0;
            s_nxt.dacCode = '0;
            s_nxt.dirty = '0;
            s_nxt.singlePend = 1'b0;
            if (word[`BIT_FULL_RST]) begin
              s_nxt.cfgIn = '0;
              s_nxt.cfgOut = '0;
              s_nxt.cfgDirty = 1'b0;
              s_nxt.stbMode = `RST_STB_MODE;
              s_nxt.powerDown = '0;
            end
          end
        endcase
      end
    end

    // Override applied before the flop, so the output is registered
    s_nxt.cfgEff = effCfg(s_nxt.cfgOut);

    // ************************************************************
    // APB slave: data set up on the setup edge, no wait states
    // ************************************************************
    apbSetup = psel & ~penable;
    apbAccess = psel & penable & s_r.pready;
    codeSel = (paddr >= `OFS_CODE0) && (paddr <= `OFS_CODE7) && (paddr[1:0] == 2'h0);
    s_nxt.pready = apbSetup;
    if (apbSetup) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      if (paddr == `OFS_CTRL) begin
        s_nxt.prdata = {31'h0000_0000, s_r.ctrlEn};
      end else if (paddr == `OFS_STATUS) begin
        s_nxt.prdata = {s_r.abortCnt, s_r.frameCnt, 5'h00, s_r.cfgDirty,
                        s_r.rx, s_r.dirty};
      end else if (paddr == `OFS_CFG) begin
        s_nxt.prdata = cfgWord(s_r);
      end else if (codeSel && !pwrite) begin
        s_nxt.prdata = {20'h0_0000, s_r.dacCode[paddr[4:2]]};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end else begin
      // Error stands for the access cycle only
      s_nxt.pslverr = 1'b0;
    end
    // Disabling drops an open frame like a short one
    if (apbAccess && pwrite && paddr == `OFS_CTRL) begin
      s_nxt.ctrlEn = pwdata[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.syncN <= 2'h3;
      s_r.sclk <= 2'h3;
      s_r.loadN <= 2'h3;
      s_r.sclkLast <= 1'b1;
      s_r.loadLast <= 1'b1;
      s_r.rx <= RX_IDLE;
      s_r.stbMode <= `RST_STB_MODE;
      s_r.ctrlEn <= `RST_CTRL_EN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs, all straight from state
  // ************************************************************
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign dacCode = s_r.dacCode;
  assign groupCfg = s_r.cfgEff;
  assign powerDown = s_r.powerDown;
  assign rxPowered = s_r.rxPowered;

endmodule : dac_word_decoder

// ---- design/dac_word_decoder_params.svh ----
// Constants for the octal converter control-word decoder.
// Assumes inclusion by the package only; the decoder module does not include it.
`ifndef DAC_WORD_DECODER_PARAMS_SVH
`define DAC_WORD_DECODER_PARAMS_SVH

`define WORD_BITS 16
`define CODE_MAX_W 12
`define CHANNELS 8

// Word fields
`define BIT_KIND 15
`define BIT_CTL_HI 14
`define BIT_CTL_LO 13
`define BIT_FULL_RST 12
`define ADDR_HI 14
`define ADDR_LO 12

// Control function codes
`define CTL_CFG 2'h0
`define CTL_STROBE 2'h1
`define CTL_PDOWN 2'h2
`define CTL_RESET 2'h3

// Strobe modes
`define STB_TRACK 2'h0
`define STB_LATCH 2'h1
`define STB_SINGLE 2'h2
`define STB_RSVD 2'h3

// Register offsets (bytes)
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CFG 12'h008
`define OFS_CODE0 12'h020
`define OFS_CODE7 12'h03C

// Reset values
`define RST_STB_MODE 2'h1
`define RST_CTRL_EN 1'h1

`endif

// ---- design/dac_word_decoder_pkg.sv ----
// Types shared by the control-word decoder and its bench.
// Assumes the params header sits on the include path.
package dac_word_decoder_pkg;
  `include "dac_word_decoder_params.svh"

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_SHIFT = 2'h1,
    RX_DONE = 2'h3
  } rxState_t;

  // Per group A-D (index 0) and E-H (index 1)
  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] buffered;
    logic [1:0] supplyRef;
  } groupCfg_t;

  typedef logic [`CHANNELS-1:0][`CODE_MAX_W-1:0] codeBank_t;

  typedef struct packed {
    logic [1:0] syncN;
    logic [1:0] sclk;
    logic [1:0] din;
    logic [1:0] loadN;
    logic sclkLast;
    logic loadLast;
    rxState_t rx;
    logic [4:0] bitCnt;
    logic [`WORD_BITS-1:0] shift;
    codeBank_t inCode;
    codeBank_t dacCode;
    logic [`CHANNELS-1:0] dirty;
    groupCfg_t cfgIn;
    groupCfg_t cfgOut;
    groupCfg_t cfgEff;
    logic cfgDirty;
    logic [1:0] stbMode;
    logic singlePend;
    logic [`CHANNELS-1:0] powerDown;
    logic rxPowered;
    logic ctrlEn;
    logic [7:0] frameCnt;
    logic [7:0] abortCnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;
endpackage : dac_word_decoder_pkg

// ---- tb/dac_word_decoder_monitor.sv ----
// Port checker for the control-word decoder.
// Assumes it is bound into the decoder by the testbench.
`timescale 1ns/1ns
module dac_word_decoder_monitor
  import dac_word_decoder_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic syncN,
  input wire logic loadStrobeN,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input codeBank_t dacCode,
  input groupCfg_t groupCfg,
  input wire logic [7:0] powerDown,
  input wire logic rxPowered
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ****************
  // Properties
  // ****************
  pready_one_a: assert property (pready |=> !pready) else $error("pready held");
  pready_answer_a: assert property (psel && !penable |=> pready) else $error("no pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  rx_off_a: assert property ($rose(syncN) |-> ##[1:4] !rxPowered) else $error("rx on");
  rx_on_a: assert property ($fell(syncN) |-> ##[1:4] rxPowered) else $error("rx off");
  supply_force_a: assert property ((groupCfg.supplyRef & (groupCfg.gain | groupCfg.buffered))
    == 2'h0) else $error("supply override lost");
  latch_hold_a: assert property ((syncN && loadStrobeN)[*8] |=> $stable(dacCode))
    else $error("outputs moved");
  pdown_commit_a: assert property (!$stable(powerDown) |-> !$past(syncN, 2))
    else $error("power-down outside frame");
  cover property ($fell(loadStrobeN));
  cover property (pslverr);
  cover property (powerDown != 8'h00);
endmodule : dac_word_decoder_monitor

// ---- tb/dac_host_model.sv ----
// Host serial port model driving the frame pins.
// Assumes sys_clk at 4 ns; link clock halves are 10 cycles.
`timescale 1ns/1ns
module dac_host_model (
  input wire logic sys_clk,
  output logic syncN,
  output logic sclk,
  output logic din
);
  initial begin
    syncN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // Fewer than 16 bits aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    int i;
    syncN <= 1'b0;
    repeat (10) @(posedge sys_clk);
    for (i = 15; i > 15 - n; i--) begin
      din <= w[i];
      repeat (10) @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (10) @(posedge sys_clk);
      sclk <= 1'b1;
    end
    din <= ~din; // Released line shows no stale bit
    repeat (10) @(posedge sys_clk);
    syncN <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask : send
endmodule : dac_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the control-word decoder.
// Assumes the host model drives frames; APB and strobe pin driven here.
`timescale 1ns/1ns
module testbench
  import dac_word_decoder_pkg::*;
;
  logic sysClk = 1'b0;
  logic rstn = 1'b0;
  logic loadStrobeN = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, syncN, sclk, din, rxPowered, er;
  codeBank_t dacCode;
  groupCfg_t groupCfg;
  logic [7:0] powerDown;
  int failCount = 0;
  int checkCount = 0;
  always #2 sysClk = ~sysClk;
  dac_host_model i_dac_host_model (.sys_clk(sysClk), .syncN(syncN), .sclk(sclk), .din(din));
  dac_word_decoder i_dac_word_decoder (.sys_clk(sysClk), .rstn(rstn), .syncN(syncN),
    .sclk(sclk), .din(din), .loadStrobeN(loadStrobeN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dacCode(dacCode), .groupCfg(groupCfg), .powerDown(powerDown),
    .rxPowered(rxPowered));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    @(posedge sysClk);
    // Waits for pready; only the watchdog ends a wait that never sees it
    while (pready !== 1'b1) @(posedge sysClk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    @(posedge sysClk);
  endtask : apb_xfer
  task automatic apb(input logic [11:0] a);
    apb_xfer(1'b0, a, 32'h0000_0000);
  endtask : apb
  task automatic send(input logic [15:0] w);
    i_dac_host_model.send(w, 16);
  endtask : send
  task automatic strobe();
    loadStrobeN <= 1'b0;
    repeat (4) @(posedge sysClk);
    loadStrobeN <= 1'b1;
    repeat (10) @(posedge sysClk);
  endtask : strobe
  // ****************
  // Scenarios
  // ****************
  task automatic s_reset();
    for (int i = 0; i < 8; i++) chk(dacCode[i], 0);
    chk({18'h0, powerDown, groupCfg}, 0);
    apb(12'h008);
    chk(rd, 32'h40);
    apb(12'h100);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask : s_reset
  task automatic s_latch();
    send(16'h3ABC);
    chk(dacCode[3], 0);
    chk(rxPowered, 1'b0);
    apb(12'h004);
    chk(rd & 32'hFFFF00FF, 32'h00010008);
    strobe();
    chk(dacCode[3], 12'hABC);
    apb(12'h004);
    chk(rd[7:0], 0);
    i_dac_host_model.send(16'h3555, 8);
    strobe();
    chk(dacCode[3], 12'hABC);
    apb(12'h004);
    chk(rd[31:24], 1);
  endtask : s_latch
  task automatic s_apb();
    apb(12'h02C);
    chk(rd, 32'h0000_0ABC);
    apb_xfer(1'b1, 12'h020, 32'h0000_0FFF);
    chk({er, dacCode[0]}, 13'h1000);
    apb_xfer(1'b1, 12'h000, 32'h0000_0000);
    chk(er, 1'b0);
    apb(12'h000);
    chk(rd, 32'h0000_0000);
    apb_xfer(1'b1, 12'h000, 32'h0000_0001);
    apb(12'h000);
    chk(rd, 32'h0000_0001);
  endtask : s_apb
  task automatic s_cfg();
    send(16'h8FFD);
    chk(groupCfg, 0);
    strobe();
    chk(groupCfg, 6'h29);
    apb(12'h008);
    chk(rd[5:0], 6'h3D);
  endtask : s_cfg
  task automatic s_modes();
    send(16'hA000);
    send(16'h0123);
    chk(dacCode[0], 12'h123);
    send(16'hA001);
    send(16'h1456);
    chk(dacCode[1], 0);
    send(16'hA002);
    chk(dacCode[1], 12'h456);
    send(16'h1789);
    send(16'hA003);
    chk(dacCode[1], 12'h456);
    apb(12'h008);
    chk(rd[7:6], 2'h2);
  endtask : s_modes
  task automatic s_resets();
    send(16'hC0A5);
    chk(powerDown, 8'hA5);
    send(16'hE000);
    chk({dacCode[0], dacCode[3]}, 0);
    chk({powerDown, groupCfg}, 14'h2969);
    send(16'hF000);
    chk({powerDown, groupCfg}, 0);
    apb(12'h008);
    chk(rd[7:6], 2'h1);
  endtask : s_resets
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge sysClk);
    rstn <= 1'b1;
    repeat (5) @(posedge sysClk);
    s_reset();
    s_latch();
    s_apb();
    s_cfg();
    s_modes();
    s_resets();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge sysClk);
    failCount++;
    wrap_up();
  end
endmodule : testbench
bind dac_word_decoder dac_word_decoder_monitor i_mon (.sys_clk(sys_clk), .rstn(rstn),
  .syncN(syncN), .loadStrobeN(loadStrobeN), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .dacCode(dacCode), .groupCfg(groupCfg), .powerDown(powerDown),
  .rxPowered(rxPowered));
